// ===== rtl/uart_cfg_pkg.sv
// Package with the register map, field positions and trigger tables of the UART config block.
`default_nettype none
package uart_cfg_pkg;
    // ----------------------------------------------------------------
    // Register byte addresses on the AXI4-Lite bus.
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_FIFO_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LINE_CTRL = 8'h04;
    localparam logic [7:0] ADDR_FEAT_CTRL = 8'h08;
    localparam logic [7:0] ADDR_ENH_FEAT = 8'h0C;
    localparam logic [7:0] ADDR_TRIG_VAL = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    // ----------------------------------------------------------------
    // Field positions.
    // ----------------------------------------------------------------
    localparam int FC_EN = 0;
    localparam int FC_RX_RST = 1;
    localparam int FC_TX_RST = 2;
    localparam int FC_DMA = 3;
    localparam int FC_TX_TRG = 4;
    localparam int FC_RX_TRG = 6;
    localparam int LC_STOP = 2;
    localparam int LC_PAR_EN = 3;
    localparam int LC_PAR_EVEN = 4;
    localparam int FT_TBL = 4;
    localparam int FT_TRG_SEL = 7;
    localparam int EF_ENH = 4;
    // ----------------------------------------------------------------
    // Reset values.
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] PROG_LVL_RST = 8'h01;
    // ----------------------------------------------------------------
    // Trigger tables, indexed by the two-bit trigger code, except table A's single TX level.
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TBL_A = 2'b00,
        TBL_B = 2'b01,
        TBL_C = 2'b10,
        TBL_PROG = 2'b11
    } table_sel_t;
    localparam logic [7:0] TX_LVL_A = 8'h01;
    localparam logic [3:0][7:0] RX_LVL_A = {8'h0E, 8'h08, 8'h04, 8'h01};
    localparam logic [3:0][7:0] TX_LVL_B = {8'h1E, 8'h18, 8'h08, 8'h10};
    localparam logic [3:0][7:0] RX_LVL_B = {8'h1C, 8'h18, 8'h10, 8'h08};
    localparam logic [3:0][7:0] TX_LVL_C = {8'h38, 8'h20, 8'h10, 8'h08};
    localparam logic [3:0][7:0] RX_LVL_C = {8'h3C, 8'h38, 8'h10, 8'h08};
    // ----------------------------------------------------------------
    // Character format encodings and bus answers.
    // ----------------------------------------------------------------
    localparam logic [3:0] WORD_BITS_MIN = 4'h5;
    localparam logic [2:0] STOP_ONE = 3'h2;
    localparam logic [2:0] STOP_ONE_HALF = 3'h3;
    localparam logic [2:0] STOP_TWO = 3'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Character format handed to the transmitter and receiver.
    typedef struct packed {
        logic [3:0] word_bits;
        logic [2:0] stop_halves;
        logic parity_en;
        logic parity_even;
    } line_fmt_t;
    // Trigger levels in characters.
    typedef struct packed {
        logic [7:0] rx;
        logic [7:0] tx;
    } trig_t;
endpackage : uart_cfg_pkg
`default_nettype wire

// ===== rtl/uart_fifo_line_cfg.sv
// AXI4-Lite register block for FIFO control, trigger levels and character format.
`default_nettype none
module uart_fifo_line_cfg
    import uart_cfg_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic resetn,
    // AXI4-Lite write channels.
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read channels.
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // FIFO levels from the data path.
    input wire logic [7:0] tx_fifo_count,
    input wire logic [7:0] rx_fifo_count,
    // Controls to the FIFOs and ready pins.
    output logic fifo_enable,
    output logic tx_fifo_reset,
    output logic rx_fifo_reset,
    output logic dma_mode,
    output trig_t trig_level,
    output logic tx_irq,
    output logic rx_irq,
    // Character format.
    output line_fmt_t line_fmt
);
    // ----------------------------------------------------------------
    // Storage.
    // ----------------------------------------------------------------
    logic aw_full_reg;        // Write address held.
    logic [7:0] aw_addr_reg;  // Held write address.
    logic w_full_reg;         // Write data held.
    logic [7:0] w_data_reg;   // Held low data byte.
    logic w_lane_reg;         // Low byte lane enabled.
    logic bvalid_reg;         // Write response pending.
    logic [1:0] bresp_reg;    // Write response code.
    logic rvalid_reg;         // Read data pending.
    logic [31:0] rdata_reg;   // Read data.
    logic [1:0] rresp_reg;    // Read response code.
    logic fifo_en_reg;        // FIFO enable.
    logic dma_reg;            // DMA mode select.
    logic [1:0] tx_code_reg;  // TX trigger code.
    logic [1:0] rx_code_reg;  // RX trigger code.
    logic tx_rst_reg;         // TX FIFO reset pulse.
    logic rx_rst_reg;         // RX FIFO reset pulse.
    logic [7:0] line_reg;     // Line control.
    logic [7:0] feat_reg;     // Feature control.
    logic [7:0] enh_reg;      // Enhanced features.
    logic [7:0] rx_prog_reg;  // Programmable RX level.
    logic [7:0] tx_prog_reg;  // Programmable TX level.
    logic [7:0] tx_prev_reg;  // TX count one cycle back.
    logic tx_over_reg;        // TX count rose above trigger since last empty.
    logic tx_irq_reg;         // TX event pulse.
    logic rx_irq_reg;         // RX level reached.
    // ----------------------------------------------------------------
    // Bus decode.
    // ----------------------------------------------------------------
    // A write goes ahead once address and data are both held and no write response is pending.
    wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    wire wr_en = do_write && w_lane_reg;
    wire wr_fc = wr_en && (aw_addr_reg == ADDR_FIFO_CTRL);
    wire wr_lc = wr_en && (aw_addr_reg == ADDR_LINE_CTRL);
    wire wr_ft = wr_en && (aw_addr_reg == ADDR_FEAT_CTRL);
    wire wr_ef = wr_en && (aw_addr_reg == ADDR_ENH_FEAT);
    wire wr_tv = wr_en && (aw_addr_reg == ADDR_TRIG_VAL);
    wire wr_map = (aw_addr_reg == ADDR_FIFO_CTRL) || (aw_addr_reg == ADDR_LINE_CTRL)
        || (aw_addr_reg == ADDR_FEAT_CTRL) || (aw_addr_reg == ADDR_ENH_FEAT)
        || (aw_addr_reg == ADDR_TRIG_VAL) || (aw_addr_reg == ADDR_STATUS);
    wire rd_take = arvalid && arready;
    // Programming of the upper FIFO control bits needs the enable bit set.
    wire fc_prog = wr_fc && w_data_reg[FC_EN];
    // TX trigger bits are writable only with enhanced features on.
    wire tx_code_wr = fc_prog && enh_reg[EF_ENH];
    // Status byte shows the block's own state.
    wire [7:0] status_val = {3'h0, tx_over_reg, rx_irq_reg, tx_irq_reg, dma_reg, fifo_en_reg};
    // Selected programmable level shown at the trigger value address.
    wire [7:0] prog_rd = feat_reg[FT_TRG_SEL] ? tx_prog_reg : rx_prog_reg;
    logic [7:0] rd_val;
    logic rd_ok;
    // Read mux; the FIFO control location returns zero.
    always_comb begin
        rd_ok = 1'b1;
        unique case (araddr)
            ADDR_FIFO_CTRL: rd_val = REG_RST;
            ADDR_LINE_CTRL: rd_val = line_reg;
            ADDR_FEAT_CTRL: rd_val = feat_reg;
            ADDR_ENH_FEAT: rd_val = enh_reg;
            ADDR_TRIG_VAL: rd_val = prog_rd;
            ADDR_STATUS: rd_val = status_val;
            default: begin
                rd_val = REG_RST;
                rd_ok = 1'b0;
            end
        endcase
    end
    // ----------------------------------------------------------------
    // Trigger table lookup.
    // ----------------------------------------------------------------
    table_sel_t tbl;
    assign tbl = table_sel_t'(feat_reg[FT_TBL +: 2]);
    // Both directions always follow the one table now selected.
    always_comb begin
        unique case (tbl)
            TBL_A: begin
                trig_level.rx = RX_LVL_A[rx_code_reg];
                trig_level.tx = TX_LVL_A;
            end
            TBL_B: begin
                trig_level.rx = RX_LVL_B[rx_code_reg];
                trig_level.tx = TX_LVL_B[tx_code_reg];
            end
            TBL_C: begin
                trig_level.rx = RX_LVL_C[rx_code_reg];
                trig_level.tx = TX_LVL_C[tx_code_reg];
            end
            TBL_PROG: begin
                trig_level.rx = rx_prog_reg;
                trig_level.tx = tx_prog_reg;
            end
        endcase
    end
    // ----------------------------------------------------------------
    // Character format decode.
    // ----------------------------------------------------------------
    wire five_bit = (line_reg[1:0] == 2'b00);
    assign line_fmt.word_bits = WORD_BITS_MIN + {2'b00, line_reg[1:0]};
    assign line_fmt.stop_halves = !line_reg[LC_STOP] ? STOP_ONE
        : (five_bit ? STOP_ONE_HALF : STOP_TWO);
    assign line_fmt.parity_en = line_reg[LC_PAR_EN];
    assign line_fmt.parity_even = line_reg[LC_PAR_EVEN];
    // ----------------------------------------------------------------
    // FIFO level events.
    // ----------------------------------------------------------------
    wire tx_below = tx_fifo_count < trig_level.tx;
    wire tx_fall = tx_below && (tx_prev_reg >= trig_level.tx);
    wire tx_empty = (tx_fifo_count == 8'h00) && (tx_prev_reg != 8'h00) && !tx_over_reg;
    wire tx_ev = fifo_en_reg && (tx_fall || tx_empty);
    wire rx_lvl = fifo_en_reg && (rx_fifo_count >= trig_level.rx);
    // ----------------------------------------------------------------
    // Outputs.
    // ----------------------------------------------------------------
    assign awready = !aw_full_reg;
    assign wready = !w_full_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = !rvalid_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign fifo_enable = fifo_en_reg;
    assign tx_fifo_reset = tx_rst_reg;
    assign rx_fifo_reset = rx_rst_reg;
    assign dma_mode = dma_reg;
    assign tx_irq = tx_irq_reg;
    assign rx_irq = rx_irq_reg;
    // ----------------------------------------------------------------
    // Write channel: address and data taken in either order.
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= REG_RST;
            w_full_reg <= 1'b0;
            w_data_reg <= REG_RST;
            w_lane_reg <= 1'b0;
        end else begin
            // Holds empty when the write is carried out.
            if (awvalid && awready) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= awaddr;
            end else if (do_write) begin
                aw_full_reg <= 1'b0;
            end
            if (wvalid && wready) begin
                w_full_reg <= 1'b1;
                w_data_reg <= wdata[7:0];
                w_lane_reg <= wstrb[0];
            end else if (do_write) begin
                w_full_reg <= 1'b0;
            end
        end
    end
    // Write response and read answer.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else begin
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid_reg <= 1'b0;
            end
            if (rd_take) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= {24'h00_0000, rd_val};
                rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end
    // ----------------------------------------------------------------
    // FIFO control register; reset bits are one-cycle pulses.
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            fifo_en_reg <= 1'b0;
            dma_reg <= 1'b0;
            tx_code_reg <= 2'b00;
            rx_code_reg <= 2'b00;
            tx_rst_reg <= 1'b0;
            rx_rst_reg <= 1'b0;
        end else begin
            tx_rst_reg <= fc_prog && w_data_reg[FC_TX_RST];
            rx_rst_reg <= fc_prog && w_data_reg[FC_RX_RST];
            if (wr_fc) begin
                fifo_en_reg <= w_data_reg[FC_EN];
            end
            // Other bits change only when the written enable bit is one.
            if (fc_prog) begin
                dma_reg <= w_data_reg[FC_DMA];
                rx_code_reg <= w_data_reg[FC_RX_TRG +: 2];
            end
            if (tx_code_wr) begin
                tx_code_reg <= w_data_reg[FC_TX_TRG +: 2];
            end
        end
    end
    // ----------------------------------------------------------------
    // Line, feature, enhanced and programmable level registers.
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            line_reg <= REG_RST;
            feat_reg <= REG_RST;
            enh_reg <= REG_RST;
            rx_prog_reg <= PROG_LVL_RST;
            tx_prog_reg <= PROG_LVL_RST;
        end else begin
            if (wr_lc) line_reg <= w_data_reg;
            if (wr_ft) feat_reg <= w_data_reg;
            if (wr_ef) enh_reg <= w_data_reg;
            // The select bit decides which level the write lands in.
            if (wr_tv && feat_reg[FT_TRG_SEL]) tx_prog_reg <= w_data_reg;
            if (wr_tv && !feat_reg[FT_TRG_SEL]) rx_prog_reg <= w_data_reg;
        end
    end
    // ----------------------------------------------------------------
    // Trigger event tracking.
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tx_prev_reg <= 8'h00;
            tx_over_reg <= 1'b0;
            tx_irq_reg <= 1'b0;
            rx_irq_reg <= 1'b0;
        end else begin
            tx_prev_reg <= tx_fifo_count;
            // Refill above trigger suppresses the plain empty event.
            if (tx_fifo_count > trig_level.tx) begin
                tx_over_reg <= 1'b1;
            end else if (tx_fifo_count == 8'h00) begin
                tx_over_reg <= 1'b0;
            end
            tx_irq_reg <= tx_ev;
            rx_irq_reg <= rx_lvl;
        end
    end
    // ----------------------------------------------------------------
    // Checks.
    // ----------------------------------------------------------------
    txrst_pulse_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        tx_fifo_reset |=> !tx_fifo_reset) else $error("TX FIFO reset held too long");
    dma_follow_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        fc_prog |=> dma_mode == $past(w_data_reg[FC_DMA])) else $error("DMA select not taken");
    tx_cause_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        tx_irq |-> $past(fifo_en_reg) && ($past(tx_fifo_count) < $past(trig_level.tx)))
        else $error("TX event without cause");
    rx_cause_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(rx_irq) |-> $past(rx_fifo_count) >= $past(trig_level.rx))
        else $error("RX event below trigger");
    table_one_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (tbl == TBL_A) |-> (trig_level.tx == TX_LVL_A)) else $error("Table one TX level wrong");
    fc_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        rd_take && (araddr == ADDR_FIFO_CTRL) |=> rdata == 32'h0000_0000)
        else $error("FIFO control read returned data");
    word_len_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_lc ##1 !wr_lc
        |=> line_fmt.word_bits == WORD_BITS_MIN + {2'b00, $past(w_data_reg[1:0], 2)})
        else $error("Word length not as written");
    stop_len_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (line_fmt.stop_halves == STOP_ONE_HALF) |-> (line_fmt.word_bits == WORD_BITS_MIN))
        else $error("Half stop bit with long word");
endmodule : uart_fifo_line_cfg
`default_nettype wire

// ===== verification/fifo_level_model.sv
// Behavioural model of the FIFO data path that reports fill levels.
`default_nettype none
module fifo_level_model (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic resetn,
    // Pointer resets from the config block.
    input wire logic tx_fifo_reset,
    input wire logic rx_fifo_reset,
    // Strobes: tx push, tx pop, rx push, rx pop.
    input wire logic [3:0] ops,
    // Fill levels back to the config block.
    output logic [7:0] tx_fifo_count,
    output logic [7:0] rx_fifo_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------------------------------------
    // Level counters.
    // --------------------------------------------------------------
    // Each strobe moves a level by one; a reset pulse empties that FIFO at once.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tx_fifo_count <= 8'h00;
            rx_fifo_count <= 8'h00;
        end else begin
            tx_fifo_count <= tx_fifo_reset ? 8'h00 : tx_fifo_count + ops[3] - ops[2];
            rx_fifo_count <= rx_fifo_reset ? 8'h00 : rx_fifo_count + ops[1] - ops[0];
        end
    end
endmodule : fifo_level_model
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the FIFO control and line format register block.
`default_nettype none
module tb import uart_cfg_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------------------------------------
    // Signals.
    // --------------------------------------------------------------
    logic ref_clk = 1'h0, resetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, d, p;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'h0, ops = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, tx_fifo_reset, rx_fifo_reset;
    logic fifo_enable, dma_mode, tx_irq, rx_irq;
    logic [1:0] bresp, rresp, resp;
    logic [7:0] tx_fifo_count, rx_fifo_count;
    trig_t trig_level;
    line_fmt_t line_fmt;
    int fail_count = 0, total_checks = 0, cycles = 0, tx_pulses = 0, txr_pulses = 0, b;
    integer seed = 32'h9311;
    uart_fifo_line_cfg dut (
        .ref_clk(ref_clk), .resetn(resetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .tx_fifo_count(tx_fifo_count),
        .rx_fifo_count(rx_fifo_count), .fifo_enable(fifo_enable),
        .tx_fifo_reset(tx_fifo_reset), .rx_fifo_reset(rx_fifo_reset), .dma_mode(dma_mode),
        .trig_level(trig_level), .tx_irq(tx_irq), .rx_irq(rx_irq), .line_fmt(line_fmt)
    );
    fifo_level_model model (
        .ref_clk(ref_clk), .resetn(resetn), .tx_fifo_reset(tx_fifo_reset),
        .rx_fifo_reset(rx_fifo_reset), .ops(ops), .tx_fifo_count(tx_fifo_count),
        .rx_fifo_count(rx_fifo_count)
    );
    // Free-running 25 MHz clock.
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    // Counts pulses and cuts a hung run short.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (tx_irq === 1'h1) tx_pulses <= tx_pulses + 1;
        if (tx_fifo_reset === 1'h1) txr_pulses <= txr_pulses + 1;
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    // --------------------------------------------------------------
    // Tasks and expectation functions.
    // --------------------------------------------------------------
    // Compares a seen value with the expected one and reports a difference.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Prints the verdict and ends the run.
    task automatic stop_test();
        if (fail_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    // One bus write; each channel is released at the edge that takes it.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic aw_done, w_done;
        aw_done = 1'h0;
        w_done = 1'h0;
        @(posedge ref_clk);
        awvalid <= 1'h1;
        awaddr <= a;
        wvalid <= 1'h1;
        wdata <= {24'h0, v};
        wstrb <= 4'hF;
        bready <= 1'h1;
        while (!(aw_done && w_done)) begin
            @(posedge ref_clk);
            if (!aw_done && awready === 1'h1) begin
                aw_done = 1'h1;
                awvalid <= 1'h0;
            end
            if (!w_done && wready === 1'h1) begin
                w_done = 1'h1;
                wvalid <= 1'h0;
            end
        end
        do @(posedge ref_clk); while (bvalid !== 1'h1);
        resp = bresp;
        bready <= 1'h0;
    endtask : wr
    // One bus read; data and response land in rd and resp.
    task automatic rd_reg(input logic [7:0] a);
        @(posedge ref_clk);
        arvalid <= 1'h1;
        araddr <= a;
        rready <= 1'h1;
        do @(posedge ref_clk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge ref_clk); while (rvalid !== 1'h1);
        rd = rdata;
        resp = rresp;
        rready <= 1'h0;
    endtask : rd_reg
    // Holds a set of FIFO strobes for n cycles.
    task automatic step(input logic [3:0] op, input int n);
        @(posedge ref_clk);
        ops <= op;
        repeat (n) @(posedge ref_clk);
        ops <= 4'h0;
    endtask : step
    // Trigger level in characters for a fixed table and code.
    function automatic logic [7:0] lvl(input int t, input int c, input bit tx);
        int rx_t[3][4] = '{'{1, 4, 8, 14}, '{8, 16, 24, 28}, '{8, 16, 56, 60}};
        int tx_t[3][4] = '{'{1, 1, 1, 1}, '{16, 8, 24, 30}, '{8, 16, 32, 56}};
        return tx ? 8'(tx_t[t][c]) : 8'(rx_t[t][c]);
    endfunction : lvl
    // Character format expected from a line control value.
    function automatic logic [8:0] fmt(input logic [7:0] v);
        logic [2:0] stop;
        stop = v[2] ? ((v[1:0] == 2'h0) ? 3'h3 : 3'h4) : 3'h2;
        return {4'(5 + v[1:0]), stop, v[3], v[4]};
    endfunction : fmt
    // --------------------------------------------------------------
    // Main sequence.
    // --------------------------------------------------------------
    initial begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'h1;
        @(posedge ref_clk);
        chk(trig_level, 16'h0101);
        chk({line_fmt, dma_mode}, {fmt(8'h00), 1'h0});
        // Every word length with both stop settings, other bits random.
        for (int i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            d[2:0] = 3'(i);
            wr(ADDR_LINE_CTRL, d);
            chk(line_fmt, fmt(d));
            rd_reg(ADDR_LINE_CTRL);
            chk(rd, {24'h0, d});
        end
        wr(ADDR_FIFO_CTRL, 8'h09);
        chk({fifo_enable, dma_mode}, 2'h3);
        rd_reg(ADDR_FIFO_CTRL);
        chk(rd, 32'h0);
        chk(resp, RESP_OKAY);
        rd_reg(8'h18);
        chk(resp, RESP_SLVERR);
        wr(8'h18, 8'hFF);
        chk(resp, RESP_SLVERR);
        wr(ADDR_FIFO_CTRL, 8'h00);
        chk({fifo_enable, dma_mode}, 2'h1);
        wr(ADDR_FIFO_CTRL, 8'h01);
        chk({fifo_enable, dma_mode}, 2'h2);
        // Fixed tables, every code, rx and tx codes set differently.
        wr(ADDR_ENH_FEAT, 8'h10);
        for (int t = 0; t < 3; t++) begin
            wr(ADDR_FEAT_CTRL, 8'(t << 4));
            for (int c = 0; c < 4; c++) begin
                wr(ADDR_FIFO_CTRL, 8'((c << 6) | ((3 - c) << 4) | 1));
                chk(trig_level, {lvl(t, c, 0), lvl(t, 3 - c, 1)});
            end
        end
        wr(ADDR_FEAT_CTRL, 8'h00);
        chk(trig_level, 16'h0E01);
        // Without enhanced features the tx code must stay as it was.
        wr(ADDR_ENH_FEAT, 8'h00);
        wr(ADDR_FEAT_CTRL, 8'h10);
        wr(ADDR_FIFO_CTRL, 8'h31);
        chk(trig_level, 16'h0810);
        // Programmable levels through the one value register.
        d = 8'($random(seed));
        p = 8'($random(seed));
        wr(ADDR_FEAT_CTRL, 8'h30);
        wr(ADDR_TRIG_VAL, d);
        wr(ADDR_FEAT_CTRL, 8'hB0);
        wr(ADDR_TRIG_VAL, p);
        chk(trig_level, {d, p});
        rd_reg(ADDR_TRIG_VAL);
        chk(rd, {24'h0, p});
        // Receive event at the level of four characters.
        wr(ADDR_FEAT_CTRL, 8'h00);
        wr(ADDR_FIFO_CTRL, 8'h41);
        step(4'h2, 3);
        repeat (3) @(posedge ref_clk);
        chk(rx_irq, 1'h0);
        step(4'h2, 1);
        repeat (3) @(posedge ref_clk);
        chk(rx_irq, 1'h1);
        // Transmit reset leaves the receive side alone.
        step(4'h8, 2);
        b = txr_pulses;
        wr(ADDR_FIFO_CTRL, 8'h45);
        @(posedge ref_clk);
        chk({8'(txr_pulses - b), tx_fifo_count, rx_fifo_count}, 24'h010004);
        // Receive reset empties the receive side as well.
        wr(ADDR_FIFO_CTRL, 8'h43);
        @(posedge ref_clk);
        chk({tx_fifo_count, rx_fifo_count}, 16'h0000);
        // Transmit events: falling below eight, then an empty after a short refill.
        wr(ADDR_ENH_FEAT, 8'h10);
        wr(ADDR_FEAT_CTRL, 8'h10);
        wr(ADDR_FIFO_CTRL, 8'h11);
        repeat (3) @(posedge ref_clk);
        b = tx_pulses;
        step(4'h8, 9);
        step(4'h4, 2);
        repeat (4) @(posedge ref_clk);
        chk(tx_pulses - b, 1);
        step(4'h4, 7);
        repeat (4) @(posedge ref_clk);
        chk(tx_pulses - b, 1);
        step(4'h8, 3);
        step(4'h4, 3);
        repeat (4) @(posedge ref_clk);
        chk(tx_pulses - b, 2);
        stop_test();
    end
endmodule : tb
`default_nettype wire
